// File: lmb_pkg.sv
// Package of constants shared by the lookup-table and manual bias register bank.
package lmb_pkg;

   // ***********************************************************************
   // Register spaces, selected beside the byte offset on the register port
   // ***********************************************************************
   localparam logic [2:0] SP_AUX  = 3'h0;   // Auxiliary slave address, 00h-7Fh.
   localparam logic [2:0] SP_MAIN = 3'h2;   // Main control table.
   localparam logic [2:0] SP_USER = 3'h3;   // Level-two user memory page.
   localparam logic [2:0] SP_MOD  = 3'h4;   // Modulation temperature table.
   localparam logic [2:0] SP_APC  = 3'h5;   // Tracking-error table.
   localparam logic [2:0] SP_VID  = 3'h6;   // Video DAC voltage table.

   // ***********************************************************************
   // Main table offsets
   // ***********************************************************************
   localparam logic [7:0] OFS_MODULATION_DAC_VALUE     = 8'h82;
   localparam logic [7:0] OFS_POWER_LOOP_REFERENCE_DAC     = 8'h83;
   localparam logic [7:0] OFS_VID_DAC     = 8'h85;
   localparam logic [7:0] OFS_RSVD_DAC1A  = 8'hc5;
   localparam logic [7:0] OFS_TABLE_SEL   = 8'hc7;
   localparam logic [7:0] OFS_MAN_UPPER   = 8'hf8;
   localparam logic [7:0] OFS_MAN_LOWER   = 8'hf9;
   localparam logic [7:0] OFS_MAN_STROBE  = 8'hfa;
   localparam logic [7:0] OFS_BIAS_UPPER  = 8'hfb;
   localparam logic [7:0] OFS_BIAS_LOWER  = 8'hfc;
   localparam logic [7:0] OFS_RSVD_TAIL   = 8'hfd;

   // ***********************************************************************
   // Table bounds, as first and last valid offsets and entries
   // ***********************************************************************
   localparam logic [7:0] OFS_TABLE_BASE  = 8'h80;
   localparam logic [7:0] OFS_MOD_LAST    = 8'hc7;
   localparam logic [7:0] OFS_APC_LAST    = 8'ha7;   // Includes reserved A4h-A7h.
   localparam logic [7:0] OFS_VID_LAST    = 8'h9f;
   localparam logic [7:0] OFS_AUX_LAST    = 8'h7f;
   localparam logic [6:0] MOD_LAST_ENTRY  = 7'h47;   // Entry C7h, +100 to +102 degrees.
   localparam logic [6:0] APC_LAST_ENTRY  = 7'h23;   // Entry A3h, +98 to +102 degrees.
   localparam logic [6:0] VID_LAST_SINGLE = 7'h1f;   // 32-entry table.
   localparam logic [6:0] VID_LAST_HALF   = 7'h0f;   // 16-entry half table.
   localparam logic [6:0] VID_HALF_BASE   = 7'h10;   // Upper half starts at 90h.

   // ***********************************************************************
   // Field positions and reset values
   // ***********************************************************************
   localparam int         SPLIT_BIT       = 1;
   localparam int         HALF_BIT        = 0;
   localparam int         STROBE_BIT      = 0;
   localparam int         BIAS_W          = 13;
   localparam logic [7:0] RST_BYTE        = 8'h00;
   localparam logic [1:0] RST_TABLE_SEL   = 2'h0;
   localparam logic [12:0] RST_BIAS       = 13'h0000;

endpackage

// File: lmb_byte_mem.sv
// Single-port byte memory with registered read data for the table contents.
`timescale 1ns/1ps
module lmb_byte_mem #(
   parameter int ADDR_W = 10,
   parameter int DATA_W = 8
) (
   // Clock.
   input  wire logic              clk_sys,
   // Access port.
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic              wrEn,
   input  wire logic [DATA_W-1:0] wrData,
   output logic      [DATA_W-1:0] rdData
);

   // ***********************************************************************
   // Storage
   // ***********************************************************************
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

   // Write through the port and always read the addressed word one cycle later.
   always_ff @(posedge clk_sys)
   begin
      if (wrEn)
      begin
         mem[addr] <= wrData;
      end
      rdData <= mem[addr];
   end

endmodule

// File: lmb_regs.sv
// Lookup-table recall, manual bias path and protected memory register bank.
`timescale 1ns/1ps
module lmb_regs #(
   parameter int MOD_RANGE_W = 3,
   parameter int APC_RANGE_W = 3
) (
   // Clock and reset.
   input  wire logic                        clk_sys,
   input  wire logic                        resetn,
   // Register port.
   input  wire logic [2:0]                  regSpace,
   input  wire logic [7:0]                  regOffset,
   input  wire logic                        regWrEn,
   input  wire logic                        regRdEn,
   input  wire logic [7:0]                  regWrData,
   output logic                             regReady,
   output logic                             regRdValid,
   output logic      [7:0]                  regRdData,
   // Control bits held outside this block.
   input  wire logic                        password_level_two,
   input  wire logic                        modulation_auto_enable,
   input  wire logic                        power_loop_auto_enable,
   input  wire logic                        video_dac_auto_enable,
   input  wire logic                        biasLoopEnable,
   input  wire logic [MOD_RANGE_W-1:0]      modRanging,
   input  wire logic [APC_RANGE_W-1:0]      apcRanging,
   input  wire logic [12:0]                 loopBiasValue,
   // Conversion results.
   input  wire logic [7:0]                  tempIndex,
   input  wire logic                        tempConvDone,
   input  wire logic [7:0]                  voltIndex,
   input  wire logic                        voltConvDone,
   // DAC controls.
   output logic [MOD_RANGE_W+7:0]           modSetPoint,
   output logic [APC_RANGE_W+7:0]           loopSetPoint,
   output logic [7:0]                       video_dac_value,
   output logic [12:0]                      laser_bias_current
);

   // ***********************************************************************
   // Types, functions and state
   // ***********************************************************************
   typedef enum logic [2:0] {ST_IDLE, ST_HOST_RD, ST_MOD_RD, ST_APC_RD, ST_VID_RD} lmb_state_t;

   // Clamp an index to the last entry of a table.
   function automatic logic [6:0] lmb_clamp(input logic [7:0] idx, input logic [6:0] last);
      lmb_clamp = (idx > {1'b0, last}) ? last : idx[6:0];
   endfunction

   // Check an offset against an inclusive range.
   function automatic logic lmb_in(input logic [7:0] ofs, input logic [7:0] lo,
                                   input logic [7:0] hi);
      lmb_in = (ofs >= lo) && (ofs <= hi);
   endfunction

   lmb_state_t        state_r;
   lmb_state_t        state_nxt;
   logic              pendTemp_r;
   logic              pendVolt_r;
   logic [2:0]        hostSpace_r;
   logic [7:0]        hostOfs_r;
   logic              hostDenied_r;
   logic              hostMem_r;
   logic [7:0]        modDac_r;
   logic [7:0]        apcDac_r;
   logic [7:0]        vidDac_r;
   logic [1:0]        tableSel_r;
   logic [5:0]        manUpper_r;
   logic [7:0]        manLower_r;
   logic              strobe_r;
   logic [12:0]       biasDac_r;
   logic              ready_r;
   logic              rdValid_r;
   logic [7:0]        rdData_r;
   logic [7:0]        rdData_nxt;
   logic [9:0]        memAddr;
   logic              memWr;
   logic [7:0]        memRdData;

   // ***********************************************************************
   // Host request decode
   // ***********************************************************************
   wire logic hostReq     = ready_r && (regWrEn || regRdEn);
   wire logic pwOk        = password_level_two;
   wire logic inAux       = (regSpace == lmb_pkg::SP_AUX)
                            && (regOffset <= lmb_pkg::OFS_AUX_LAST);
   wire logic inUser      = (regSpace == lmb_pkg::SP_USER)
                            && (regOffset >= lmb_pkg::OFS_TABLE_BASE);
   wire logic inMod       = (regSpace == lmb_pkg::SP_MOD)
                            && lmb_in(regOffset, lmb_pkg::OFS_TABLE_BASE, lmb_pkg::OFS_MOD_LAST);
   wire logic inApc       = (regSpace == lmb_pkg::SP_APC)
                            && lmb_in(regOffset, lmb_pkg::OFS_TABLE_BASE, lmb_pkg::OFS_APC_LAST);
   wire logic inVid       = (regSpace == lmb_pkg::SP_VID)
                            && lmb_in(regOffset, lmb_pkg::OFS_TABLE_BASE, lmb_pkg::OFS_VID_LAST);
   wire logic inMem       = inAux || inUser || inMod || inApc || inVid;
   wire logic inMain      = (regSpace == lmb_pkg::SP_MAIN);
   wire logic hostWr      = hostReq && regWrEn && pwOk;
   wire logic mainWr      = hostWr && inMain;
   wire logic wrModDac    = mainWr && (regOffset == lmb_pkg::OFS_MODULATION_DAC_VALUE)
                            && !modulation_auto_enable;
   wire logic wrApcDac    = mainWr && (regOffset == lmb_pkg::OFS_POWER_LOOP_REFERENCE_DAC)
                            && !power_loop_auto_enable;
   wire logic wrVidDac    = mainWr && (regOffset == lmb_pkg::OFS_VID_DAC)
                            && !video_dac_auto_enable;
   wire logic wrTableSel  = mainWr && (regOffset == lmb_pkg::OFS_TABLE_SEL);
   wire logic wrManUpper  = mainWr && (regOffset == lmb_pkg::OFS_MAN_UPPER)
                            && !biasLoopEnable;
   wire logic wrManLower  = mainWr && (regOffset == lmb_pkg::OFS_MAN_LOWER)
                            && !biasLoopEnable;
   wire logic wrStrobe    = mainWr && (regOffset == lmb_pkg::OFS_MAN_STROBE);
   // A transfer happens on every write with the bit set while biasLoopEnable is low; the clearing write only clears strobe_r.
   wire logic biasLoad    = wrStrobe && regWrData[lmb_pkg::STROBE_BIT]
                            && !biasLoopEnable;

   // ***********************************************************************
   // Table index arithmetic
   // ***********************************************************************
   wire logic [6:0] modEntry = lmb_clamp(tempIndex, lmb_pkg::MOD_LAST_ENTRY);
   wire logic [6:0] apcEntry = lmb_clamp({1'b0, tempIndex[7:1]},
                                         lmb_pkg::APC_LAST_ENTRY);
   wire logic       splitTbl = tableSel_r[lmb_pkg::SPLIT_BIT];
   wire logic       upperHalf = tableSel_r[lmb_pkg::HALF_BIT];
   wire logic [6:0] vidSingle = lmb_clamp(voltIndex, lmb_pkg::VID_LAST_SINGLE);
   wire logic [6:0] vidHalf   = lmb_clamp(voltIndex, lmb_pkg::VID_LAST_HALF);
   wire logic [6:0] vidEntry  = !splitTbl ? vidSingle
                                : (upperHalf ? (vidHalf | lmb_pkg::VID_HALF_BASE)
                                             : vidHalf);

   // ***********************************************************************
   // Memory arbitration
   // ***********************************************************************
   // Host accesses win while idle; recall requests wait as pending flags, so a
   // conversion is never lost, only delayed for as long as host requests keep arriving.
   wire logic idleHost = (state_r == ST_IDLE) && hostReq;
   wire logic goMod    = (state_r == ST_IDLE) && !hostReq && pendTemp_r;
   wire logic goVid    = (state_r == ST_IDLE) && !hostReq && !pendTemp_r && pendVolt_r;
   wire logic goApc    = (state_r == ST_MOD_RD);

   assign memWr = hostWr && inMem;
   assign memAddr = idleHost ? {regSpace, regOffset[6:0]}
                  : goMod    ? {lmb_pkg::SP_MOD, modEntry}
                  : goApc    ? {lmb_pkg::SP_APC, apcEntry}
                  : goVid    ? {lmb_pkg::SP_VID, vidEntry}
                  : {hostSpace_r, hostOfs_r[6:0]};

   lmb_byte_mem #(
      .ADDR_W (10),
      .DATA_W (8)
   ) u_mem (
      .clk_sys (clk_sys),
      .addr    (memAddr),
      .wrEn    (memWr),
      .wrData  (regWrData),
      .rdData  (memRdData)
   );

   // ***********************************************************************
   // Sequencer
   // ***********************************************************************
   // Next state for host reads and table recall.
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE:
         begin
            if (idleHost && regRdEn)
               state_nxt = ST_HOST_RD;
            else if (goMod)
               state_nxt = ST_MOD_RD;
            else if (goVid)
               state_nxt = ST_VID_RD;
         end
         ST_HOST_RD: state_nxt = ST_IDLE;
         ST_MOD_RD:  state_nxt = ST_APC_RD;
         ST_APC_RD:  state_nxt = ST_IDLE;
         ST_VID_RD:  state_nxt = ST_IDLE;
      endcase
   end

   // State, pending conversions and latched host request.
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         state_r      <= ST_IDLE;
         pendTemp_r   <= 1'b0;
         pendVolt_r   <= 1'b0;
         hostSpace_r  <= lmb_pkg::SP_AUX;
         hostOfs_r    <= lmb_pkg::RST_BYTE;
         hostDenied_r <= 1'b0;
         hostMem_r    <= 1'b0;
         ready_r      <= 1'b0;
      end
      else
      begin
         state_r    <= state_nxt;
         // A new conversion in the launch cycle stays pending: set wins.
         pendTemp_r <= tempConvDone || (pendTemp_r && !goMod);
         pendVolt_r <= voltConvDone || (pendVolt_r && !goVid);
         ready_r    <= (state_nxt == ST_IDLE) && !(idleHost && regRdEn);
         if (idleHost)
         begin
            hostSpace_r  <= regSpace;
            hostOfs_r    <= regOffset;
            hostDenied_r <= !pwOk;
            hostMem_r    <= inMem;
         end
      end
   end

   // ***********************************************************************
   // DAC value registers
   // ***********************************************************************
   // Recall only lands while the matching auto mode is on; otherwise the host owns it.
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         modDac_r <= lmb_pkg::RST_BYTE;
         apcDac_r <= lmb_pkg::RST_BYTE;
         vidDac_r <= lmb_pkg::RST_BYTE;
      end
      else
      begin
         if (state_r == ST_MOD_RD && modulation_auto_enable)
            modDac_r <= memRdData;
         else if (wrModDac)
            modDac_r <= regWrData;
         if (state_r == ST_APC_RD && power_loop_auto_enable)
            apcDac_r <= memRdData;
         else if (wrApcDac)
            apcDac_r <= regWrData;
         if (state_r == ST_VID_RD && video_dac_auto_enable)
            vidDac_r <= memRdData;
         else if (wrVidDac)
            vidDac_r <= regWrData;
      end
   end

   // Set points combine the held DAC bytes with the ranging bits.
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         modSetPoint     <= '0;
         loopSetPoint    <= '0;
         video_dac_value <= lmb_pkg::RST_BYTE;
      end
      else
      begin
         modSetPoint     <= {modRanging, modDac_r};
         loopSetPoint    <= {apcRanging, apcDac_r};
         video_dac_value <= vidDac_r;
      end
   end

   // ***********************************************************************
   // Table select and manual bias path
   // ***********************************************************************
   // Volatile manual bias bytes, strobe bit and the applied bias DAC value.
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         tableSel_r <= lmb_pkg::RST_TABLE_SEL;
         manUpper_r <= '0;
         manLower_r <= lmb_pkg::RST_BYTE;
         strobe_r   <= 1'b0;
         biasDac_r  <= lmb_pkg::RST_BIAS;
      end
      else
      begin
         if (wrTableSel)
            tableSel_r <= regWrData[1:0];
         if (wrManUpper)
            manUpper_r <= regWrData[5:0];
         if (wrManLower)
            manLower_r <= regWrData;
         if (wrStrobe)
            strobe_r <= regWrData[lmb_pkg::STROBE_BIT];
         // With the loop running the loop owns the DAC; manual loads need it off.
         if (biasLoopEnable)
            biasDac_r <= loopBiasValue;
         else if (biasLoad)
            biasDac_r <= {manUpper_r, manLower_r[6:0]};
      end
   end

   assign laser_bias_current = biasDac_r;

   // ***********************************************************************
   // Read data
   // ***********************************************************************
   // Main-table read mux; unknown and reserved offsets read as zero.
   always_comb
   begin
      rdData_nxt = lmb_pkg::RST_BYTE;
      if (hostDenied_r)
         rdData_nxt = lmb_pkg::RST_BYTE;
      else if (hostSpace_r != lmb_pkg::SP_MAIN)
      begin
         // Only offsets inside a table or page return memory; unmapped words read zero.
         if (hostMem_r)
            rdData_nxt = memRdData;
      end
      else
      begin
         unique case (hostOfs_r)
            lmb_pkg::OFS_MODULATION_DAC_VALUE:    rdData_nxt = modDac_r;
            lmb_pkg::OFS_POWER_LOOP_REFERENCE_DAC:    rdData_nxt = apcDac_r;
            lmb_pkg::OFS_VID_DAC:    rdData_nxt = vidDac_r;
            lmb_pkg::OFS_TABLE_SEL:  rdData_nxt = {6'h00, tableSel_r};
            lmb_pkg::OFS_MAN_UPPER:  rdData_nxt = {2'h0, manUpper_r};
            lmb_pkg::OFS_MAN_LOWER:  rdData_nxt = manLower_r;
            lmb_pkg::OFS_MAN_STROBE: rdData_nxt = {7'h00, strobe_r};
            lmb_pkg::OFS_BIAS_UPPER: rdData_nxt = {2'h0, biasDac_r[12:7]};
            lmb_pkg::OFS_BIAS_LOWER: rdData_nxt = {1'b0, biasDac_r[6:0]};
            default:                 rdData_nxt = lmb_pkg::RST_BYTE;
         endcase
      end
   end

   // Read answer is registered one cycle after the memory word appears.
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         rdValid_r <= 1'b0;
         rdData_r  <= lmb_pkg::RST_BYTE;
      end
      else
      begin
         rdValid_r <= (state_r == ST_HOST_RD);
         if (state_r == ST_HOST_RD)
            rdData_r <= rdData_nxt;
      end
   end

   assign regReady   = ready_r;
   assign regRdValid = rdValid_r;
   assign regRdData  = rdData_r;

endmodule

// File: lmb_regs_assertions.sv
// Checker of register port timing, protection and bias DAC readback.
`timescale 1ns/1ps
module lmb_regs_assertions #(
   parameter int MOD_RANGE_W = 3,
   parameter int APC_RANGE_W = 3
) (
   // Clock, reset and register port.
   input wire logic                   clk_sys,
   input wire logic                   resetn,
   input wire logic [2:0]             regSpace,
   input wire logic [7:0]             regOffset,
   input wire logic                   regWrEn,
   input wire logic                   regRdEn,
   input wire logic [7:0]             regWrData,
   input wire logic                   regReady,
   input wire logic                   regRdValid,
   input wire logic [7:0]             regRdData,
   // Controls and DAC values.
   input wire logic                   password_level_two,
   input wire logic                   biasLoopEnable,
   input wire logic                   tempConvDone,
   input wire logic [MOD_RANGE_W-1:0] modRanging,
   input wire logic [APC_RANGE_W-1:0] apcRanging,
   input wire logic [MOD_RANGE_W+7:0] modSetPoint,
   input wire logic [APC_RANGE_W+7:0] loopSetPoint,
   input wire logic [12:0]            laser_bias_current
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // Taken requests; the strobe only counts when it carries a one in bit zero.
   wire rdTake = regReady && regRdEn;
   wire strobe = regReady && regWrEn && regSpace == lmb_pkg::SP_MAIN
                 && regOffset == lmb_pkg::OFS_MAN_STROBE && regWrData[0];
   chk_read_answer: assert property (rdTake |-> ##2 regRdValid)
      else $error("Read data not presented two cycles after the take.");
   chk_valid_pulse: assert property (regRdValid |=> !regRdValid)
      else $error("Read valid held longer than one cycle.");
   chk_ready_after_read: assert property (rdTake |=> !regReady)
      else $error("Ready stayed high after a read take.");
   chk_locked_read: assert property (rdTake && !password_level_two |-> ##2 regRdData == 8'h00)
      else $error("Read without password returned data.");
   chk_readback_top: assert property (rdTake && regSpace == lmb_pkg::SP_MAIN
      && regOffset == lmb_pkg::OFS_BIAS_UPPER |-> ##2 regRdData[7:6] == 2'b00)
      else $error("Upper bias readback has nonzero top bits.");
   // The bias DAC may move in manual mode only after a strobe write.
   chk_strobe_only: assert property ($changed(laser_bias_current) && !biasLoopEnable
      && !$past(biasLoopEnable) |-> $past(strobe) || $past(strobe, 2))
      else $error("Bias DAC changed without a strobe.");
   chk_mod_ranging: assert property ($past(resetn)
      |-> modSetPoint[MOD_RANGE_W+7:8] == $past(modRanging))
      else $error("Modulation set point lost its ranging bits.");
   chk_apc_ranging: assert property ($past(resetn)
      |-> loopSetPoint[APC_RANGE_W+7:8] == $past(apcRanging))
      else $error("Loop set point lost its ranging bits.");
   cover property (strobe);
   cover property (rdTake && !password_level_two);
   cover property (tempConvDone);
endmodule
bind lmb_regs lmb_regs_assertions #(.MOD_RANGE_W(MOD_RANGE_W), .APC_RANGE_W(APC_RANGE_W)) i_chk (.*);

// File: lmb_regs_tb.sv
// Self-checking bench of the lookup-table and manual bias register bank.
`timescale 1ns/1ps
module lmb_regs_tb;
   localparam logic [2:0] MN = lmb_pkg::SP_MAIN;
   logic        clk_sys = 0, resetn = 0, regWrEn = 0, regRdEn = 0, regReady, regRdValid;
   logic        password_level_two = 1, modulation_auto_enable = 1, power_loop_auto_enable = 1;
   logic        video_dac_auto_enable = 1, biasLoopEnable = 0, tempConvDone = 0, voltConvDone = 0;
   logic [2:0]  regSpace = 0, modRanging = 3'h5, apcRanging = 3'h6;
   logic [7:0]  regOffset = 0, regWrData = 0, regRdData, tempIndex = 0, voltIndex = 0;
   logic [7:0]  video_dac_value;
   logic [12:0] loopBiasValue = 13'h0123, laser_bias_current;
   logic [10:0] modSetPoint, loopSetPoint;
   logic [7:0]  selTab [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h00, 8'h02, 8'h03};
   logic [7:0]  idxTab [7] = '{8'h03, 8'h03, 8'h03, 8'h03, 8'hff, 8'hff, 8'hff};
   logic [7:0]  expTab [7] = '{8'ha1, 8'ha1, 8'ha1, 8'hb2, 8'hc3, 8'hd4, 8'hc3};
   int          mismatches = 0, samples_checked = 0;
   lmb_regs i_lmb_regs (.*);
   task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // One request, driven once ready is seen high and held for one edge; a stuck port ends the run.
   task automatic req(logic rd, logic [2:0] sp, logic [7:0] ofs, logic [7:0] d);
      int i;
      // An edge always passes first, so the strobe dropped by the last call is seen low.
      for (i = 0; i < 40; i++)
      begin
         @(posedge clk_sys) #2;
         if (regReady === 1'b1)
            break;
      end
      if (i == 40)
      begin
         mismatches++;
         summarize();
      end
      {regRdEn, regWrEn, regSpace, regOffset, regWrData} = {rd, !rd, sp, ofs, d};
      @(posedge clk_sys) #2;
      {regRdEn, regWrEn} = 2'b00;
   endtask
   task automatic wr(logic [2:0] sp, logic [7:0] ofs, logic [7:0] d);
      req(0, sp, ofs, d);
   endtask
   task automatic rd(string nm, logic [2:0] sp, logic [7:0] ofs, logic [7:0] exp);
      req(1, sp, ofs, 8'h00);
      // Valid stands only in the cycle after the edge that follows the take.
      @(posedge clk_sys);
      #2;
      chk("read valid", regRdValid, 1'b1);
      chk(nm, regRdData, exp);
   endtask
   // A one-cycle conversion pulse, then time for the recall to land.
   task automatic pulse(logic v);
      {voltConvDone, tempConvDone} = {v, !v};
      @(posedge clk_sys) #2;
      {voltConvDone, tempConvDone} = 2'b00;
      repeat (8) @(posedge clk_sys);
      #2;
   endtask
   initial
   begin
      forever #12.5 clk_sys = ~clk_sys;
   end
   initial
   begin
      repeat (3) @(posedge clk_sys);
      #2;
      resetn = 1;
      chk("bias reset", laser_bias_current, 13'h0000);
      wr(lmb_pkg::SP_AUX, 8'h7f, 8'ha5);
      wr(lmb_pkg::SP_USER, 8'hff, 8'h3c);
      rd("aux", lmb_pkg::SP_AUX, 8'h7f, 8'ha5);
      rd("user", lmb_pkg::SP_USER, 8'hff, 8'h3c);
      password_level_two = 0;
      wr(lmb_pkg::SP_AUX, 8'h7f, 8'h5a);
      rd("locked", lmb_pkg::SP_AUX, 8'h7f, 8'h00);
      password_level_two = 1;
      rd("unlocked", lmb_pkg::SP_AUX, 8'h7f, 8'ha5);
      wr(MN, 8'hc5, 8'hff);
      rd("reserved", MN, 8'hc5, 8'h00);
      // Manual bias: value, strobe set, strobe clear, each a write of its own.
      wr(MN, 8'hf8, 8'h2a);
      wr(MN, 8'hf9, 8'h55);
      wr(MN, 8'hfa, 8'h01);
      @(posedge clk_sys) #2;
      chk("bias", laser_bias_current, 13'h1555);
      wr(MN, 8'hfa, 8'h00);
      wr(MN, 8'hfb, 8'hff);
      rd("bias upper", MN, 8'hfb, 8'h2a);
      rd("bias lower", MN, 8'hfc, 8'h55);
      biasLoopEnable = 1;
      wr(MN, 8'hf8, 8'h00);
      chk("loop bias", laser_bias_current, 13'h0123);
      biasLoopEnable = 0;
      wr(MN, 8'hfa, 8'h01);
      wr(MN, 8'hfa, 8'h00);
      chk("kept bias", laser_bias_current, 13'h1555);
      // Temperature recall, in range and past the last entry.
      wr(lmb_pkg::SP_MOD, 8'h85, 8'h11);
      wr(lmb_pkg::SP_MOD, 8'hc7, 8'h77);
      wr(lmb_pkg::SP_APC, 8'h82, 8'h22);
      wr(lmb_pkg::SP_APC, 8'ha3, 8'h33);
      tempIndex = 8'h05;
      pulse(0);
      chk("mod", modSetPoint, {3'h5, 8'h11});
      chk("apc", loopSetPoint, {3'h6, 8'h22});
      tempIndex = 8'hff;
      pulse(0);
      chk("mod last", modSetPoint, {3'h5, 8'h77});
      chk("apc last", loopSetPoint, {3'h6, 8'h33});
      // Manual mode: host values survive conversions.
      {modulation_auto_enable, power_loop_auto_enable, video_dac_auto_enable} = 3'b000;
      wr(MN, 8'h82, 8'h9c);
      wr(MN, 8'h83, 8'h3e);
      wr(MN, 8'h85, 8'h4d);
      pulse(0);
      pulse(1);
      chk("mod manual", modSetPoint, {3'h5, 8'h9c});
      chk("apc manual", loopSetPoint, {3'h6, 8'h3e});
      chk("video manual", video_dac_value, 8'h4d);
      video_dac_auto_enable = 1;
      // Video table in single and split modes, both halves, clamped indexes.
      wr(lmb_pkg::SP_VID, 8'h83, 8'ha1);
      wr(lmb_pkg::SP_VID, 8'h93, 8'hb2);
      wr(lmb_pkg::SP_VID, 8'h9f, 8'hc3);
      wr(lmb_pkg::SP_VID, 8'h8f, 8'hd4);
      for (int k = 0; k < 7; k++)
      begin
         wr(MN, lmb_pkg::OFS_TABLE_SEL, selTab[k]);
         voltIndex = idxTab[k];
         pulse(1);
         chk("video", video_dac_value, expTab[k]);
      end
      summarize();
   end
endmodule
